// File: sxs_alu.sv
/*
  datapath for subtract, xor and nibble swap on a file register, with the
  working register and status flags held here.
  assumes the file read data arrives in the request cycle (same clock) and the
  register file applies file_wr_en / file_wr_addr / file_wr_data on its next edge.
  ops may come back to back; an op that reads the file register written by the op
  just before it needs the register file to forward that write, since nothing here
  holds a copy of file contents.
  the decoder presents op_valid for one cycle per op; a no-op code is refused.
*/
`timescale 1ns/1ps
module sxs_alu
  import sxs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // request from decode
  input wire logic op_valid,
  input wire sxs_pkg::sxs_op_e op,
  input wire logic dest_sel,
  input wire logic [sxs_pkg::ADDR_W-1:0] file_addr,
  input wire logic [sxs_pkg::DATA_W-1:0] file_rd_data,
  // write back to file
  output logic file_wr_en,
  output logic [sxs_pkg::ADDR_W-1:0] file_wr_addr,
  output logic [sxs_pkg::DATA_W-1:0] file_wr_data,
  // architectural state
  output logic [sxs_pkg::DATA_W-1:0] work_reg,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic zero_flag,
  output logic op_done
);
  typedef struct packed {
    sxs_state_e state;
    logic [DATA_W-1:0] work;
    logic [2:0] flags;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic done;
  } sxs_regs_s;

  sxs_regs_s cur, next_cur;
  logic [DATA_W-1:0] res;
  logic [2:0] new_flags;

  // swap and digit carry need a byte of exactly two nibbles and three distinct flag bits;
  // any other layout would quietly pick the wrong bits, so elaboration stops instead
  if (DATA_W != 2 * NIB_W || NIB_LO != 0 || NIB_HI != NIB_W
      || FLAG_C == FLAG_DC || FLAG_C == FLAG_Z || FLAG_DC == FLAG_Z
      || FLAG_C > 2 || FLAG_DC > 2 || FLAG_Z > 2) begin : g_bad_layout
    $error("sxs_alu: byte, nibble or flag layout not supported");
  end

  // combinational result and flags for the op on the inputs this cycle
  sxs_calc i_sxs_calc (
    .op(op),
    .work_val(cur.work),
    .file_val(file_rd_data),
    .flags_in(cur.flags),
    .result(res),
    .flags_out(new_flags)
  );

  // one place decides whether a request is taken, shared by the next-state logic and idle_hold_a, done_pulse_a and addr_hold_a;
  // a refused code must leave every output as it was, except file_wr_en and op_done, which drop low
  function automatic logic op_taken(input logic valid, input sxs_op_e code);
    return valid && (code != sxs_no_op);
  endfunction

  // one op per cycle; the done state only marks the answer, no stall needed
  always_comb begin
    next_cur = cur;
    next_cur.wr_en = 1'b0;
    next_cur.done = 1'b0;
    case (cur.state)
      SXS_IDLE, SXS_DONE: begin
        next_cur.state = SXS_IDLE;
        if (op_taken(op_valid, op)) begin
          next_cur.state = SXS_DONE;
          next_cur.done = 1'b1;
          next_cur.flags = new_flags;
          // working destination: write address and data keep their last values
          if (dest_sel == DEST_WORK) begin
            next_cur.work = res;
          end else begin
            // file destination: the working register is left alone
            next_cur.wr_en = 1'b1;
            next_cur.wr_addr = file_addr;
            next_cur.wr_data = res;
          end
        end
      end
      // a state code that is not one-hot falls back to idle without touching the datapath
      default: begin
        next_cur.state = SXS_IDLE;
      end
    endcase
  end

  // register the whole state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cur <= '{state: SXS_IDLE, work: WORK_RST, flags: FLAGS_RST, wr_en: 1'b0,
               wr_addr: '0, wr_data: '0, done: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  // every output comes straight from the state register
  assign file_wr_en = cur.wr_en;
  assign file_wr_addr = cur.wr_addr;
  assign file_wr_data = cur.wr_data;
  assign work_reg = cur.work;
  assign carry_flag = cur.flags[FLAG_C];
  assign digit_carry_flag = cur.flags[FLAG_DC];
  assign zero_flag = cur.flags[FLAG_Z];
  assign op_done = cur.done;

  // checks: each ties the outcome one cycle later to the request
  sub_result_a: assert property (@(posedge clk) disable iff (!nrst)
    op_valid && op == sub_work_from_file_op && !dest_sel |=>
    work_reg == $past(file_rd_data) - $past(cur.work))
    else $error("subtract result wrong");
  sub_carry_a: assert property (@(posedge clk) disable iff (!nrst)
    op_valid && op == sub_work_from_file_op |=> carry_flag == ($past(file_rd_data) >= $past(cur.work)))
    else $error("subtract carry wrong");
  xor_result_a: assert property (@(posedge clk) disable iff (!nrst)
    op_valid && op == xor_work_with_file_op && dest_sel |=>
    file_wr_en && file_wr_data == ($past(file_rd_data) ^ $past(cur.work)))
    else $error("xor result wrong");
  xor_keeps_carry_a: assert property (@(posedge clk) disable iff (!nrst)
    op_valid && op == xor_work_with_file_op |=> $stable(carry_flag) && $stable(digit_carry_flag))
    else $error("xor touched carry flags");
  swap_result_a: assert property (@(posedge clk) disable iff (!nrst)
    op_valid && op == nibble_swap_file_op && !dest_sel |=>
    work_reg == {$past(file_rd_data[3:0]), $past(file_rd_data[7:4])})
    else $error("swap result wrong");
  swap_flags_a: assert property (@(posedge clk) disable iff (!nrst)
    op_valid && op == nibble_swap_file_op |=> $stable({carry_flag, digit_carry_flag, zero_flag}))
    else $error("swap changed flags");
  dest_work_a: assert property (@(posedge clk) disable iff (!nrst)
    op_valid && op != sxs_no_op && !dest_sel |=> !file_wr_en)
    else $error("file written for working destination");
  dest_file_a: assert property (@(posedge clk) disable iff (!nrst)
    op_valid && op != sxs_no_op && dest_sel |=> file_wr_en && $stable(work_reg)
    && file_wr_addr == $past(file_addr))
    else $error("file write back wrong");
  zero_flag_a: assert property (@(posedge clk) disable iff (!nrst)
    op_valid && op == sub_work_from_file_op && dest_sel |=> zero_flag == (file_wr_data == 8'h00))
    else $error("zero flag wrong");

  // remaining result paths: each op to the destination the first checks leave open
  sub_file_a: assert property (@(posedge clk) disable iff (!nrst)
    op_valid && op == sub_work_from_file_op && dest_sel |=>
    file_wr_en && file_wr_data == $past(file_rd_data) - $past(cur.work))
    else $error("subtract write back wrong");
  xor_work_a: assert property (@(posedge clk) disable iff (!nrst)
    op_valid && op == xor_work_with_file_op && !dest_sel |=>
    work_reg == ($past(file_rd_data) ^ $past(cur.work)))
    else $error("xor working result wrong");
  swap_file_a: assert property (@(posedge clk) disable iff (!nrst)
    op_valid && op == nibble_swap_file_op && dest_sel |=>
    file_wr_en && file_wr_data == {$past(file_rd_data[3:0]), $past(file_rd_data[7:4])})
    else $error("swap write back wrong");

  // flags still open; digit carry is not-borrow out of the low nibble
  sub_digit_a: assert property (@(posedge clk) disable iff (!nrst)
    op_valid && op == sub_work_from_file_op |=>
    digit_carry_flag == ($past(file_rd_data[3:0]) >= $past(cur.work[3:0])))
    else $error("subtract digit carry wrong");
  sub_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    op_valid && op == sub_work_from_file_op && !dest_sel |=>
    zero_flag == (work_reg == 8'h00))
    else $error("subtract zero flag wrong");
  xor_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    op_valid && op == xor_work_with_file_op |=>
    zero_flag == (($past(file_rd_data) ^ $past(cur.work)) == 8'h00))
    else $error("xor zero flag wrong");

  // refused requests and stray pulses: nothing may move without a taken op
  idle_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !op_taken(op_valid, op) |=>
    !file_wr_en && !op_done && $stable(work_reg) && $stable(file_wr_addr) && $stable(file_wr_data)
    && $stable({carry_flag, digit_carry_flag, zero_flag}))
    else $error("refused request changed state");
  done_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
    op_taken(op_valid, op) |=> op_done)
    else $error("taken op not acknowledged");
  wr_source_a: assert property (@(posedge clk) disable iff (!nrst)
    file_wr_en |->
    $past(op_valid) && $past(dest_sel) && $past(op) != sxs_no_op)
    else $error("file write without a file destination op");
  addr_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    op_taken(op_valid, op) && dest_sel == DEST_WORK |=>
    !file_wr_en && $stable(file_wr_addr) && $stable(file_wr_data))
    else $error("working destination touched write back");
  done_source_a: assert property (@(posedge clk) disable iff (!nrst)
    op_done |->
    $past(op_valid) && $past(op) != sxs_no_op)
    else $error("done without a taken op");

  // reset is asynchronous, so the outputs must already be clear at any edge seen under reset
  reset_values_a: assert property (@(posedge clk)
    !nrst |->
    work_reg == WORK_RST && {zero_flag, digit_carry_flag, carry_flag} == FLAGS_RST
    && !file_wr_en && !op_done)
    else $error("outputs not at reset values");

  // scenarios worth seeing at least once
  sub_zero_c: cover property (@(posedge clk) disable iff (!nrst)
    op_valid && op == sub_work_from_file_op ##1 zero_flag);
  xor_file_c: cover property (@(posedge clk) disable iff (!nrst)
    op_valid && op == xor_work_with_file_op && dest_sel);
  swap_back_c: cover property (@(posedge clk) disable iff (!nrst)
    op_valid && op == nibble_swap_file_op ##1 op_valid && op == sub_work_from_file_op);
  sub_borrow_c: cover property (@(posedge clk) disable iff (!nrst)
    op_valid && op == sub_work_from_file_op && !dest_sel ##1 !carry_flag);
  nop_refused_c: cover property (@(posedge clk) disable iff (!nrst)
    op_valid && op == sxs_no_op);
endmodule

// File: sxs_pkg.sv
/*
  package for the subtract / xor / nibble-swap datapath: operation codes,
  flag positions, widths and reset values.
  assumes the core decodes instructions elsewhere and hands over one op at a time.
*/
// How it works
// - subtract computes file minus working register, two's complement; updates carry, digit carry, zero.
// - xor combines working and file register bitwise; only the zero flag changes.
// - swap exchanges file nibbles 3:0 and 7:4; no status flag changes.
// - destination bit 0 writes working register, 1 writes back to file register.
package sxs_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int NIB_LO = 0;   // low nibble starts here
  localparam int NIB_HI = 4;   // high nibble starts here
  localparam int NIB_W = 4;
  localparam int FLAG_C = 0;   // carry position in the flag word
  localparam int FLAG_DC = 1;  // digit carry position
  localparam int FLAG_Z = 2;   // zero position
  localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
  localparam logic [2:0] FLAGS_RST = 3'h0;
  localparam logic DEST_WORK = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  typedef enum logic [1:0] {
    sub_work_from_file_op = 2'h0,
    xor_work_with_file_op = 2'h1,
    nibble_swap_file_op = 2'h2,
    sxs_no_op = 2'h3
  } sxs_op_e;

  typedef enum logic [1:0] {
    SXS_IDLE = 2'h1,
    SXS_DONE = 2'h2
  } sxs_state_e;
endpackage

// File: sxs_calc.sv
/*
  combinational result and flag calculator for one operation.
  assumes operands are stable in the same cycle; holds no state.
*/
`timescale 1ns/1ps
module sxs_calc
  import sxs_pkg::*;
(
  // operation and operands
  input wire sxs_pkg::sxs_op_e op,
  input wire logic [sxs_pkg::DATA_W-1:0] work_val,
  input wire logic [sxs_pkg::DATA_W-1:0] file_val,
  input wire logic [2:0] flags_in,
  // outcome
  output logic [sxs_pkg::DATA_W-1:0] result,
  output logic [2:0] flags_out
);
  logic [DATA_W:0] diff;
  logic [NIB_W:0] ndiff;

  // borrow shows as carry clear, as on most small cores
  always_comb begin
    diff = {1'b0, file_val} + {1'b0, ~work_val} + {{DATA_W{1'b0}}, 1'b1};
    ndiff = {1'b0, file_val[NIB_W-1:0]} + {1'b0, ~work_val[NIB_W-1:0]} + {{NIB_W{1'b0}}, 1'b1};
    flags_out = flags_in;
    result = file_val;
    case (op)
      sub_work_from_file_op: begin
        result = diff[DATA_W-1:0];
        flags_out[FLAG_C] = diff[DATA_W];
        flags_out[FLAG_DC] = ndiff[NIB_W];
        flags_out[FLAG_Z] = (diff[DATA_W-1:0] == 8'h00);
      end
      xor_work_with_file_op: begin
        result = work_val ^ file_val;
        flags_out[FLAG_Z] = ((work_val ^ file_val) == 8'h00);
      end
      nibble_swap_file_op: begin
        result = {file_val[NIB_LO +: NIB_W], file_val[NIB_HI +: NIB_W]};
      end
      default: begin
        result = file_val;
      end
    endcase
  end
endmodule

// File: tb_subtract_xor_swap_alu_ops.sv
/*
  self-checking bench for the subtract / xor / nibble-swap datapath.
  assumes the file read data is presented with the request, as the register file would.
*/
`timescale 1ns/1ps
module tb_subtract_xor_swap_alu_ops;
  import sxs_pkg::*;
  logic clk, nrst, op_valid, dest_sel;
  sxs_op_e op;
  logic [ADDR_W-1:0] file_addr, file_wr_addr;
  logic [DATA_W-1:0] file_rd_data, file_wr_data, work_reg;
  logic file_wr_en, carry_flag, digit_carry_flag, zero_flag, op_done;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [26:0] notes[$];
  logic [31:0] seed = 32'hf8816b54;
  wire logic [26:0] seen = {file_wr_en, file_wr_addr, file_wr_data, work_reg, carry_flag, digit_carry_flag, zero_flag};

  sxs_alu i_sxs_alu (.clk(clk), .nrst(nrst), .op_valid(op_valid), .op(op), .dest_sel(dest_sel),
    .file_addr(file_addr), .file_rd_data(file_rd_data), .file_wr_en(file_wr_en),
    .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data), .work_reg(work_reg),
    .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag), .op_done(op_done));

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  task automatic check(input string name, input logic [26:0] exp, input logic [26:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // falling edge: registered outputs have settled; a done with nothing noted means a refused op acted
  always @(negedge clk) begin
    if (nrst === 1'b1 && op_done !== 1'b0) begin
      if (notes.size() == 0) check("op_done", 27'h0, 27'h1);
      else check("result", notes.pop_front(), seen);
    end
  end

  // driver keeps its own working register and flags; a quarter of operands equal w to hit zero
  initial begin
    logic [7:0] w, f, r, wd;
    logic [6:0] wa;
    logic c, dc, z, we;
    w = 8'h00; wd = 8'h00; wa = 7'h00; c = 1'b0; dc = 1'b0; z = 1'b0; we = 1'b0;
    nrst = 1'b0; op_valid = 1'b0; op = sxs_no_op; dest_sel = 1'b0; file_addr = 7'h00; file_rd_data = 8'h00;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    check("reset", 27'h0, seen);
    for (int i = 0; i < 400; i++) begin
      seed = xorshift(seed);
      f = (seed[30:29] == 2'h0) ? w : seed[7:0];
      @(posedge clk);
      op_valid <= seed[10] | seed[11];
      op <= sxs_op_e'(seed[9:8]);
      dest_sel <= seed[12];
      file_addr <= seed[19:13];
      file_rd_data <= f;
      if ((seed[10] | seed[11]) && seed[9:8] != 2'h3) begin
        case (seed[9:8])
          2'h0: begin
            r = f - w;
            c = (f >= w);
            dc = (f[3:0] >= w[3:0]);
            z = (r == 8'h00);
          end
          2'h1: begin
            r = f ^ w;
            z = (r == 8'h00);
          end
          default: r = {f[3:0], f[7:4]};
        endcase
        we = seed[12];
        if (seed[12]) begin
          wa = seed[19:13];
          wd = r;
        end else begin
          w = r;
        end
        notes.push_back({we, wa, wd, w, c, dc, z});
      end
    end
    @(posedge clk);
    op_valid <= 1'b0;
    for (int k = 0; k < 10 && notes.size() != 0; k++) @(posedge clk);
    if (notes.size() != 0) begin
      $display("unexpected pending expected 0 seen %0d", notes.size());
      error_cnt++;
    end
    wrap_up();
  end
endmodule
